// ### rtc_map.vh
`ifndef RTC_MAP_VH
`define RTC_MAP_VH

// ****************************************************************
// Register offsets (byte addresses on the APB)
// ****************************************************************
`define ADDR_W       8
`define OFF_TIME     8'h00
`define OFF_CTRL     8'h04
`define OFF_ALARM1   8'h08
`define OFF_ALARM2   8'h0c
`define OFF_SWATCH   8'h10
`define OFF_STATUS   8'h14
`define OFF_MASK     8'h18

// ****************************************************************
// Time word layout (TIME, ALARM1, ALARM2)
// ****************************************************************
`define SEC_LSB      0
`define SEC_MSB      5
`define MIN_LSB      8
`define MIN_MSB      13
`define HOUR_LSB     16
`define HOUR_MSB     20
`define DAY_LSB      24
`define DAY_MSB      31
`define SEC_MAX      6'h3b
`define MIN_MAX      6'h3b
`define HOUR_MAX     5'h17

// ****************************************************************
// Control bits
// ****************************************************************
`define CTRL_W       4
`define CTRL_AL1     0
`define CTRL_AL2     1
`define CTRL_SW      2
`define CTRL_WAKE    3

// ****************************************************************
// Status and mask bits
// ****************************************************************
`define ST_W         6
`define ST_SEC       0
`define ST_MIN       1
`define ST_DAY       2
`define ST_AL1       3
`define ST_AL2       4
`define ST_SW        5

// ****************************************************************
// Stopwatch and prescaler
// ****************************************************************
`define SW_W         16
`define PRE_W        16
`define PRE_DIV_DEF  16'h8000

`endif

// ### rtc_edge_sync.v
`timescale 1ns/1ns

module rtc_edge_sync
(
  pclk,
  presetn,
  pin_in,
  rise
);
  input  wire pclk;
  input  wire presetn;
  input  wire pin_in;
  output wire rise;

  reg meta_r;
  reg sync_r;
  reg prev_r;
  reg rise_r;

  // ****************************************************************
  // Two-flop synchroniser, edge detect only on the second flop
  // ****************************************************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_r <= 1'h0;
      sync_r <= 1'h0;
      prev_r <= 1'h0;
      rise_r <= 1'h0;
    end
    else
    begin
      meta_r <= pin_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
      rise_r <= sync_r & ~prev_r;
    end
  end

  assign rise = rise_r;

endmodule // rtc_edge_sync

// ### rtc_prescaler.v
`timescale 1ns/1ns
`include "rtc_map.vh"

module rtc_prescaler
#(
  parameter [`PRE_W-1:0] DIV = `PRE_DIV_DEF
)
(
  pclk,
  presetn,
  edge_in,
  tick
);
  input  wire pclk;
  input  wire presetn;
  input  wire edge_in;
  output wire tick;

  reg [`PRE_W-1:0] cnt_r;
  reg              tick_r;

  // ****************************************************************
  // Crystal edge counter
  // ****************************************************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_r  <= {`PRE_W{1'h0}};
      tick_r <= 1'h0;
    end
    else
    begin
      tick_r <= 1'h0;
      if (edge_in)
      begin
        if (cnt_r >= DIV - {{(`PRE_W-1){1'h0}}, 1'h1})
        begin
          cnt_r  <= {`PRE_W{1'h0}};
          tick_r <= 1'h1;
        end
        else
        begin
          cnt_r <= cnt_r + {{(`PRE_W-1){1'h0}}, 1'h1};
        end
      end
    end
  end

  assign tick = tick_r;

endmodule // rtc_prescaler

// ### calendar_clock_alarm_stopwatch.v
`timescale 1ns/1ns
`include "rtc_map.vh"

// Contract
// - Prescale crystal edges to one-second tick
// - Seconds, minutes, hours, days cascaded counters
// - Enabled alarm interrupts on counter match
// - First alarm matches time of day
// - Second alarm matches day and time
// - Stopwatch loads, decrements once per minute
// - Enabled stopwatch underflow raises interrupt
// - Selectable second, minute, day tick interrupts
// - Keeps counting during processor low power
// - Any interrupt can wake the processor
// - Wake only when wakeup enable set
module calendar_clock_alarm_stopwatch
#(
  parameter [`PRE_W-1:0] PRE_DIV = `PRE_DIV_DEF
)
(
  pclk,
  presetn,
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  prdata,
  pready,
  pslverr,
  xtal_in,
  irq,
  wake_req
);
  input  wire               pclk;
  input  wire               presetn;
  input  wire               psel;
  input  wire               penable;
  input  wire               pwrite;
  input  wire [`ADDR_W-1:0] paddr;
  input  wire [31:0]        pwdata;
  output wire [31:0]        prdata;
  output wire               pready;
  output wire               pslverr;
  input  wire               xtal_in;
  output wire               irq;
  output wire               wake_req;

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  function [31:0] pack_time;
    input [5:0] s;
    input [5:0] m;
    input [4:0] h;
    input [7:0] d;
    begin
      pack_time                          = 32'h0000_0000;
      pack_time[`SEC_MSB:`SEC_LSB]       = s;
      pack_time[`MIN_MSB:`MIN_LSB]       = m;
      pack_time[`HOUR_MSB:`HOUR_LSB]     = h;
      pack_time[`DAY_MSB:`DAY_LSB]       = d;
    end
  endfunction

  function addr_hit;
    input [`ADDR_W-1:0] a;
    begin
      case (a)
        `OFF_TIME,
        `OFF_CTRL,
        `OFF_ALARM1,
        `OFF_ALARM2,
        `OFF_SWATCH,
        `OFF_STATUS,
        `OFF_MASK: addr_hit = 1'h1;
        default:   addr_hit = 1'h0;
      endcase
    end
  endfunction

  // ****************************************************************
  // Declarations
  // ****************************************************************
  reg [5:0]         sec_r;
  reg [5:0]         min_r;
  reg [4:0]         hour_r;
  reg [7:0]         day_r;
  reg [`CTRL_W-1:0] ctrl_r;
  reg [5:0]         al1_sec_r;
  reg [5:0]         al1_min_r;
  reg [4:0]         al1_hour_r;
  reg [5:0]         al2_sec_r;
  reg [5:0]         al2_min_r;
  reg [4:0]         al2_hour_r;
  reg [7:0]         al2_day_r;
  reg [`SW_W-1:0]   sw_r;
  reg               sw_arm_r;
  reg [`ST_W-1:0]   status_r;
  reg [`ST_W-1:0]   status_nxt;
  reg [`ST_W-1:0]   mask_r;
  reg               tick_d_r;
  reg [31:0]        prdata_r;
  reg [31:0]        rd_mux;
  reg               irq_r;
  reg               wake_r;

  wire              xtal_rise;
  wire              sec_tick;
  wire              sec_wrap;
  wire              min_wrap;
  wire              hour_wrap;
  wire              hit;
  wire              wr_en;
  wire              rd_setup;
  wire              wr_time;
  wire              wr_ctrl;
  wire              wr_al1;
  wire              wr_al2;
  wire              wr_sw;
  wire              wr_status;
  wire              wr_mask;
  wire              al1_ev;
  wire              al2_ev;
  wire              sw_ev;
  wire [`ST_W-1:0]  ev;
  wire [`ST_W-1:0]  clr;

  // ****************************************************************
  // Crystal input and prescaler
  // ****************************************************************
  // The crystal is far slower than pclk, so plain oversampling is safe
  rtc_edge_sync u_sync
  (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_in  (xtal_in),
    .rise    (xtal_rise)
  );

  rtc_prescaler #(.DIV(PRE_DIV)) u_pre
  (
    .pclk    (pclk),
    .presetn (presetn),
    .edge_in (xtal_rise),
    .tick    (sec_tick)
  );

  // ****************************************************************
  // APB decode
  // ****************************************************************
  assign hit       = addr_hit(paddr);
  assign wr_en     = psel & penable & pwrite & hit;
  assign rd_setup  = psel & ~penable & ~pwrite;
  assign wr_time   = wr_en & (paddr == `OFF_TIME);
  assign wr_ctrl   = wr_en & (paddr == `OFF_CTRL);
  assign wr_al1    = wr_en & (paddr == `OFF_ALARM1);
  assign wr_al2    = wr_en & (paddr == `OFF_ALARM2);
  assign wr_sw     = wr_en & (paddr == `OFF_SWATCH);
  assign wr_status = wr_en & (paddr == `OFF_STATUS);
  assign wr_mask   = wr_en & (paddr == `OFF_MASK);

  assign pready    = 1'h1;
  assign pslverr   = psel & penable & ~hit;

  // ****************************************************************
  // Time-keeping cascade
  // ****************************************************************
  // Compare with >= so an out-of-range value written by software
  // still wraps at the next tick instead of running to all ones
  assign sec_wrap  = sec_tick & (sec_r >= `SEC_MAX);
  assign min_wrap  = sec_wrap & (min_r >= `MIN_MAX);
  assign hour_wrap = min_wrap & (hour_r >= `HOUR_MAX);

  // No low-power input gates this block; it counts whatever the core does
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sec_r  <= 6'h00;
      min_r  <= 6'h00;
      hour_r <= 5'h00;
      day_r  <= 8'h00;
    end
    else if (wr_time)
    begin
      sec_r  <= pwdata[`SEC_MSB:`SEC_LSB];
      min_r  <= pwdata[`MIN_MSB:`MIN_LSB];
      hour_r <= pwdata[`HOUR_MSB:`HOUR_LSB];
      day_r  <= pwdata[`DAY_MSB:`DAY_LSB];
    end
    else
    begin
      if (sec_tick)
      begin
        sec_r <= sec_wrap ? 6'h00 : sec_r + 6'h01;
      end
      if (sec_wrap)
      begin
        min_r <= min_wrap ? 6'h00 : min_r + 6'h01;
      end
      if (min_wrap)
      begin
        hour_r <= hour_wrap ? 5'h00 : hour_r + 5'h01;
      end
      if (hour_wrap)
      begin
        day_r <= day_r + 8'h01;
      end
    end
  end

  // ****************************************************************
  // Control and alarm settings
  // ****************************************************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r     <= {`CTRL_W{1'h0}};
      al1_sec_r  <= 6'h00;
      al1_min_r  <= 6'h00;
      al1_hour_r <= 5'h00;
      al2_sec_r  <= 6'h00;
      al2_min_r  <= 6'h00;
      al2_hour_r <= 5'h00;
      al2_day_r  <= 8'h00;
      mask_r     <= {`ST_W{1'h0}};
    end
    else
    begin
      if (wr_ctrl)
      begin
        ctrl_r <= pwdata[`CTRL_W-1:0];
      end
      if (wr_al1)
      begin
        al1_sec_r  <= pwdata[`SEC_MSB:`SEC_LSB];
        al1_min_r  <= pwdata[`MIN_MSB:`MIN_LSB];
        al1_hour_r <= pwdata[`HOUR_MSB:`HOUR_LSB];
      end
      if (wr_al2)
      begin
        al2_sec_r  <= pwdata[`SEC_MSB:`SEC_LSB];
        al2_min_r  <= pwdata[`MIN_MSB:`MIN_LSB];
        al2_hour_r <= pwdata[`HOUR_MSB:`HOUR_LSB];
        al2_day_r  <= pwdata[`DAY_MSB:`DAY_LSB];
      end
      if (wr_mask)
      begin
        mask_r <= pwdata[`ST_W-1:0];
      end
    end
  end

  // ****************************************************************
  // Alarm comparators
  // ****************************************************************
  // Checked one cycle after the tick, once the counters show the new
  // second; a time write that lands on a match does not fire unless it comes in the sec_tick cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tick_d_r <= 1'h0;
    end
    else
    begin
      tick_d_r <= sec_tick;
    end
  end

  assign al1_ev = tick_d_r & ctrl_r[`CTRL_AL1] &
                  (sec_r == al1_sec_r) & (min_r == al1_min_r) &
                  (hour_r == al1_hour_r);
  assign al2_ev = tick_d_r & ctrl_r[`CTRL_AL2] &
                  (sec_r == al2_sec_r) & (min_r == al2_min_r) &
                  (hour_r == al2_hour_r) & (day_r == al2_day_r);

  // ****************************************************************
  // Stopwatch
  // ****************************************************************
  // Disarms at underflow so it reports once per load, not every minute
  assign sw_ev = sec_wrap & ctrl_r[`CTRL_SW] & sw_arm_r &
                 (sw_r == {`SW_W{1'h0}}) & ~wr_sw;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sw_r     <= {`SW_W{1'h0}};
      sw_arm_r <= 1'h0;
    end
    else if (wr_sw)
    begin
      sw_r     <= pwdata[`SW_W-1:0];
      sw_arm_r <= 1'h1;
    end
    else if (sec_wrap & ctrl_r[`CTRL_SW] & sw_arm_r)
    begin
      if (sw_r == {`SW_W{1'h0}})
      begin
        sw_arm_r <= 1'h0;
      end
      else
      begin
        sw_r <= sw_r - {{(`SW_W-1){1'h0}}, 1'h1};
      end
    end
  end

  // ****************************************************************
  // Interrupt status, mask and wake
  // ****************************************************************
  assign ev[`ST_SEC] = sec_tick;
  assign ev[`ST_MIN] = sec_wrap;
  assign ev[`ST_DAY] = hour_wrap;
  assign ev[`ST_AL1] = al1_ev;
  assign ev[`ST_AL2] = al2_ev;
  assign ev[`ST_SW]  = sw_ev;

  assign clr = wr_status ? pwdata[`ST_W-1:0] : {`ST_W{1'h0}};

  // A new event wins over a write-one-to-clear in the same cycle
  always @*
  begin
    status_nxt = (status_r & ~clr) | ev;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status_r <= {`ST_W{1'h0}};
      irq_r    <= 1'h0;
      wake_r   <= 1'h0;
    end
    else
    begin
      status_r <= status_nxt;
      irq_r    <= |(status_r & mask_r);
      wake_r   <= |(status_r & mask_r) & ctrl_r[`CTRL_WAKE];
    end
  end

  assign irq      = irq_r;
  assign wake_req = wake_r;

  // ****************************************************************
  // Read path
  // ****************************************************************
  always @*
  begin
    case (paddr)
      `OFF_TIME:   rd_mux = pack_time(sec_r, min_r, hour_r, day_r);
      `OFF_CTRL:   rd_mux = {{(32-`CTRL_W){1'h0}}, ctrl_r};
      `OFF_ALARM1: rd_mux = pack_time(al1_sec_r, al1_min_r, al1_hour_r, 8'h00);
      `OFF_ALARM2: rd_mux = pack_time(al2_sec_r, al2_min_r, al2_hour_r, al2_day_r);
      `OFF_SWATCH: rd_mux = {{(32-`SW_W){1'h0}}, sw_r};
      `OFF_STATUS: rd_mux = {{(32-`ST_W){1'h0}}, status_r};
      `OFF_MASK:   rd_mux = {{(32-`ST_W){1'h0}}, mask_r};
      default:     rd_mux = 32'h0000_0000;
    endcase
  end

  // Captured in the setup cycle so the access phase can finish at once
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_r <= 32'h0000_0000;
    end
    else if (rd_setup)
    begin
      prdata_r <= rd_mux;
    end
  end

  assign prdata = prdata_r;

endmodule // calendar_clock_alarm_stopwatch

// ### rtc_check_asserts.sv
`timescale 1ns/1ns
`include "rtc_map.vh"

module rtc_check
#(
  parameter [`PRE_W-1:0] PRE_DIV = `PRE_DIV_DEF
)
(
  input wire               pclk,
  input wire               presetn,
  input wire               psel,
  input wire               penable,
  input wire               pwrite,
  input wire [`ADDR_W-1:0] paddr,
  input wire [31:0]        pwdata,
  input wire [31:0]        prdata,
  input wire               pready,
  input wire               pslverr,
  input wire               xtal_in,
  input wire               irq,
  input wire               wake_req
);
  // ******************************
  // Shadows of wake enable and mask
  // ******************************
  wire            hit = (paddr[1:0] == 2'b00) && (paddr <= `OFF_MASK);
  wire            wr  = psel && penable && pwrite;
  reg             wake_en_r;
  reg [`ST_W-1:0] mask_r;

  always @(posedge pclk or negedge presetn)
    if (!presetn)
      wake_en_r <= 1'b0;
    else if (wr && paddr == `OFF_CTRL)
      wake_en_r <= pwdata[`CTRL_WAKE];

  always @(posedge pclk or negedge presetn)
    if (!presetn)
      mask_r <= {`ST_W{1'b0}};
    else if (wr && paddr == `OFF_MASK)
      mask_r <= pwdata[`ST_W-1:0];

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ready_always: assert property (pready)
    else $error("pready low");
  a_slverr_unmapped: assert property (pslverr == (psel && penable && !hit))
    else $error("pslverr wrong");
  a_unmapped_reads_zero: assert property (psel && penable && !pwrite && !hit |-> prdata == 0)
    else $error("unmapped read not zero");
  a_prdata_holds: assert property (!$past(psel && !penable && !pwrite) |-> $stable(prdata))
    else $error("prdata moved without read");
  a_wake_needs_irq: assert property (wake_req |-> irq)
    else $error("wake without irq");
  a_wake_gated: assert property (wake_req == (irq && $past(wake_en_r)))
    else $error("wake_req not irq and enable");
  a_mask_blocks_irq: assert property ($past(mask_r) == 0 |-> !irq)
    else $error("irq with all masked");
  a_irq_sticky: assert property ($fell(irq) |-> $past(wr, 2))
    else $error("irq fell without write");

  cover property ($rose(irq));
  cover property ($rose(wake_req));
  cover property (pslverr);
endmodule // rtc_check

bind calendar_clock_alarm_stopwatch rtc_check #(.PRE_DIV(PRE_DIV)) u_chk
(
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .xtal_in(xtal_in), .irq(irq), .wake_req(wake_req)
);

// ### tb.sv
`timescale 1ns/1ns
`include "rtc_map.vh"

module tb;
  // ******************************
  // Short prescale: one second is 32 pclk
  // ******************************
  localparam [`PRE_W-1:0] DIV = 16'h0004;
  typedef struct packed {logic [7:0] a; logic [31:0] w; logic [31:0] r; logic e;} row_t;
  reg               pclk;
  reg               presetn;
  reg               psel;
  reg               penable;
  reg               pwrite;
  reg               xtal_in;
  reg [`ADDR_W-1:0] paddr;
  reg [31:0]        pwdata;
  reg [31:0]        rd;
  reg               err;
  reg [2:0]         xc;
  wire [31:0]       prdata;
  wire              pready;
  wire              pslverr;
  wire              irq;
  wire              wake_req;
  integer           fail_count;
  integer           total_checks;
  integer           i;
  row_t             rows [0:5];

  calendar_clock_alarm_stopwatch #(.PRE_DIV(DIV)) DUT
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .xtal_in(xtal_in), .irq(irq), .wake_req(wake_req)
  );

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Crystal half period of 4 pclk keeps clear of the synchroniser limit
  always @(posedge pclk) xc <= xc + 3'd1;
  always @(posedge pclk) xtal_in <= xc[2];

  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    begin
      total_checks = total_checks + 1;
      if (g !== e)
      begin
        $display("ERROR %s expected %h seen %h", nm, e, g);
        fail_count = fail_count + 1;
      end
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    integer n;
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 50; n = n + 1)
      begin
        @(posedge pclk);
        if (pready === 1'b1)
          break;
      end
      if (n == 50)
      begin
        fail_count = fail_count + 1;
        report_and_stop;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  // Clears all status, then polls until the next second tick lands
  task sync;
    integer n;
    begin
      apb(1'b1, `OFF_STATUS, 32'h3f);
      for (n = 0; n < 40; n = n + 1)
      begin
        apb(1'b0, `OFF_STATUS, 32'h0);
        if (rd[`ST_SEC] === 1'b1)
          break;
      end
      if (n == 40)
      begin
        fail_count = fail_count + 1;
        report_and_stop;
      end
    end
  endtask

  task rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    begin
      apb(1'b0, a, 32'h0);
      chk(nm, e, rd);
    end
  endtask

  initial
  begin
    fail_count = 0;
    total_checks = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    xc = 3'd0;
    xtal_in = 1'b0;
    rows[0] = '{`OFF_SWATCH, 32'h1234abcd, 32'h0000abcd, 1'b0};
    rows[1] = '{`OFF_CTRL, 32'hffffffff, 32'h0000000f, 1'b0};
    rows[2] = '{`OFF_ALARM1, 32'hff1f3f3f, 32'h001f3f3f, 1'b0};
    rows[3] = '{`OFF_ALARM2, 32'hff1f3f3f, 32'hff1f3f3f, 1'b0};
    rows[4] = '{`OFF_MASK, 32'hffffffff, 32'h0000003f, 1'b0};
    rows[5] = '{8'h1c, 32'hffffffff, 32'h0, 1'b1};
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i <= 6; i = i + 1)
      rdchk("reset value", 8'(4 * i), 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
    $display("done: reset");
    for (i = 0; i < 6; i = i + 1)
    begin
      apb(1'b1, rows[i].a, rows[i].w);
      apb(1'b0, rows[i].a, 32'h0);
      chk("readback", rows[i].r, rd);
      chk("pslverr", {31'h0, rows[i].e}, {31'h0, err});
    end
    $display("done: register rows");
    apb(1'b1, `OFF_CTRL, 32'h0);
    apb(1'b1, `OFF_MASK, 32'h0);
    sync;
    apb(1'b1, `OFF_TIME, 32'hff173b3b);
    sync;
    rdchk("time wrap", `OFF_TIME, 32'h0);
    rdchk("tick flags", `OFF_STATUS, 32'h07);
    chk("irq masked", 32'h0, {31'h0, irq});
    $display("done: wrap");
    apb(1'b1, `OFF_TIME, 32'h050a141e);
    apb(1'b1, `OFF_ALARM1, 32'h770a141f);
    apb(1'b1, `OFF_ALARM2, 32'h060a141f);
    apb(1'b1, `OFF_CTRL, 32'h0b);
    apb(1'b1, `OFF_MASK, 32'h08);
    sync;
    repeat (4) @(posedge pclk);
    rdchk("alarm flags", `OFF_STATUS, 32'h09);
    chk("irq", 32'h1, {31'h0, irq});
    chk("wake", 32'h1, {31'h0, wake_req});
    apb(1'b1, `OFF_STATUS, 32'h08);
    repeat (2) @(posedge pclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    sync;
    apb(1'b1, `OFF_TIME, 32'h060a141e);
    apb(1'b1, `OFF_CTRL, 32'h03);
    apb(1'b1, `OFF_MASK, 32'h10);
    sync;
    repeat (4) @(posedge pclk);
    rdchk("day alarm flags", `OFF_STATUS, 32'h19);
    chk("irq", 32'h1, {31'h0, irq});
    chk("wake off", 32'h0, {31'h0, wake_req});
    $display("done: alarms");
    sync;
    apb(1'b1, `OFF_TIME, 32'h0000003b);
    apb(1'b1, `OFF_SWATCH, 32'h1);
    apb(1'b1, `OFF_CTRL, 32'h04);
    apb(1'b1, `OFF_MASK, 32'h20);
    sync;
    rdchk("count", `OFF_SWATCH, 32'h0);
    rdchk("no underflow yet", `OFF_STATUS, 32'h03);
    apb(1'b1, `OFF_TIME, 32'h0000003b);
    sync;
    repeat (4) @(posedge pclk);
    rdchk("underflow", `OFF_STATUS, 32'h23);
    chk("irq", 32'h1, {31'h0, irq});
    $display("done: stopwatch");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("ctrl after reset", `OFF_CTRL, 32'h0);
    chk("irq after reset", 32'h0, {31'h0, irq});
    $display("done: second reset");
    report_and_stop;
  end
endmodule // tb
